// *** verilog/asc_curve.sv ***
// analog input scaling curves: sampling, filter, range alarm, curve mapping
// assumes measurement sources and settings come from logic on clk_sys
`timescale 1ns/1ps
`default_nettype none
module asc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  // fill side
  input  wire logic         s_valid,
  output logic              s_ready,
  input  wire logic [W-1:0] s_data,
  // drain side
  output logic              m_valid,
  input  wire logic         m_ready,
  output logic [W-1:0]      m_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;
  wire          wr = s_valid && s_ready;
  wire          rd = m_valid && m_ready;
  // full when pointers differ only in the wrap bit
  assign s_ready = (wp_r ^ rp_r) != {1'b1, {AW{1'b0}}};
  assign m_valid = wp_r != rp_r;
  assign m_data  = mem[rp_r[AW-1:0]];
  always_ff @(posedge clk_sys) begin
    if (wr) mem[wp_r[AW-1:0]] <= s_data;
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_r + (AW+1)'(wr);
      rp_r <= rp_r + (AW+1)'(rd);
    end
  end
endmodule // asc_fifo

module asc_curve import asc_pkg::*; #(
  parameter int NCH      = `ASC_NCH,
  parameter int NPT      = `ASC_NPT,
  parameter int TICK_CYC = `ASC_TICK_CYC,
  parameter int FDEPTH   = `ASC_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  // measurement sources
  input  wire asc_val_t             meas_val [`ASC_NSRC],
  input  wire logic [`ASC_NSRC-1:0] meas_valid,
  // per channel settings and curve points
  input  wire asc_cfg_t             cfg [NCH],
  input  wire asc_pt_t              pt [NCH][NPT],
  // status
  output asc_val_t                  curve_input_value [NCH],
  output asc_val_t                  curve_output_value [NCH],
  output logic [NCH-1:0]            curve_input_range_alarm
);
  if (NCH < 1 || NCH > 16 || NPT < 2 || NPT > 32 || TICK_CYC < 2) $error("bad parameters");
  // every property below runs on the system clock and sleeps in reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // 5 ms enable pulse
  logic [31:0] div_r;
  logic        tick_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= div_r == 32'(TICK_CYC - 1);
      div_r  <= (div_r == 32'(TICK_CYC - 1)) ? 32'h0 : div_r + 32'h1;
    end
  end

  // per channel update-cycle counters
  logic [NCH-1:0] due_set;
  logic [NCH-1:0] en_mask;
  logic [NCH-1:0] due_r;
  logic [NCH-1:0] rng_mask;
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [10:0] cnt_r;
    assign en_mask[c] = cfg[c].en;
    assign rng_mask[c] = cfg[c].en && cfg[c].range_en;
    assign due_set[c] = tick_r && cfg[c].en && (cnt_r + 11'h1 >= cfg[c].upd);
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) cnt_r <= '0;
      else if (!cfg[c].en) cnt_r <= '0;
      else if (tick_r) cnt_r <= due_set[c] ? 11'h0 : cnt_r + 11'h1;
    end
    // no alarm while checking is off
    property p_range_off;
      !cfg[c].range_en || !cfg[c].en |=> !curve_input_range_alarm[c];
    endproperty
    a_range_off: assert property (p_range_off) else $error("alarm while check off");
    property p_dis;
      !cfg[c].en |=> !due_r[c];
    endproperty
    a_dis: assert property (p_dis) else $error("disabled channel sampled");
  end

  // sample stage: lowest due channel, one per cycle, stalled by a full fifo
  logic [NCH-1:0] pick_oh;
  logic [3:0]     pick_idx;
  logic           f_ready;
  asc_val_t       filt_r [NCH];
  assign pick_oh = due_r & (~due_r + NCH'(1));
  always_comb begin
    pick_idx = 4'h0;
    for (int i = 0; i < NCH; i++) if (pick_oh[i]) pick_idx = 4'(i);
  end
  wire            push  = (due_r != '0) && f_ready;
  asc_cfg_t       pc;
  assign pc = cfg[pick_idx];
  wire asc_val_t  x_raw = meas_val[pc.src];
  wire            x_ok  = meas_valid[pc.src];
  wire asc_val_t  y_old = filt_r[pick_idx];
  wire asc_val_t  x_dif = x_raw - y_old;
  // y += (x - y) * update / tau, both in 5 ms steps; x once tau is short
  wire logic signed [`ASC_DW+12:0] f_prod = x_dif * $signed({1'b0, pc.upd});
  wire logic signed [`ASC_DW+12:0] f_step = f_prod / $signed({1'b0, pc.tau});
  wire asc_val_t  y_new = ({9'h0, pc.upd} >= pc.tau) ? x_raw : y_old + `ASC_DW'(f_step);
  // averaged or raw, hold on signal loss
  wire asc_val_t  push_val = !x_ok ? curve_input_value[pick_idx] :
                             pc.filt_en ? y_new : x_raw;
  // outside either limit, only when enabled
  wire            out_rng = pc.en && pc.range_en &&
                            (push_val < pc.lim_lo || push_val > pc.lim_hi);

  // due flags: a new due wins over the clear of the one taken
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) due_r <= '0;
    else due_r <= ((due_r & ~(push ? pick_oh : '0)) | due_set) & en_mask;
  end

  // input status, filter state and alarms
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NCH; i++) begin
        filt_r[i]            <= '0;
        curve_input_value[i] <= '0;
      end
      curve_input_range_alarm <= '0;
    end else begin
      // alarm drops as soon as checking is switched off
      curve_input_range_alarm <= curve_input_range_alarm & rng_mask;
      if (push) begin
        if (x_ok) filt_r[pick_idx] <= pc.filt_en ? y_new : x_raw;
        curve_input_value[pick_idx]       <= push_val;
        curve_input_range_alarm[pick_idx] <= out_rng;
      end
    end
  end

  // samples wait here while the curve engine is busy
  asc_smp_t f_out;
  logic     f_valid;
  wire      f_pop;
  asc_fifo #(.W($bits(asc_smp_t)), .DEPTH(FDEPTH)) u_fifo (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .s_valid (due_r != '0),
    .s_ready (f_ready),
    .s_data  ({pick_idx, push_val}),
    .m_valid (f_valid),
    .m_ready (f_pop),
    .m_data  (f_out)
  );

  // curve engine
  asc_st_t  st_r;
  logic [3:0] ch_r;
  asc_val_t x_r;
  asc_val_t y_r;
  logic [4:0] k_r;
  logic [4:0] lo_r;
  logic [4:0] hi_r;
  logic [4:0] prev_r;
  assign f_pop = st_r == S_IDLE;
  asc_pt_t  kp;
  asc_pt_t  plo;
  asc_pt_t  phi;
  assign kp  = pt[ch_r][k_r];
  assign plo = pt[ch_r][lo_r];
  assign phi = pt[ch_r][hi_r];
  // first two points always used, the rest by flag
  wire k_used = (k_r == 5'h1) || kp.used;
  wire k_last = k_r == 5'(NPT - 1);
  // linear interpolation, extrapolating past the end points
  wire asc_val_t den = phi.in - plo.in;
  wire logic signed [2*`ASC_DW+1:0] num = (x_r - plo.in) * (phi.out - plo.out);
  wire asc_val_t y_int = (den == '0) ? plo.out : plo.out + `ASC_DW'(num / den);

  // floor to a whole multiple of the scale unit
  function automatic asc_val_t fl(input asc_val_t v);
    asc_val_t q;
    q = v / `ASC_SCALE;
    if (v < 0 && q * `ASC_SCALE != v) q = q - 1;
    return q * `ASC_SCALE;
  endfunction
  asc_rnd_t rm;
  assign rm = cfg[ch_r].rnd;
  wire asc_val_t y_rnd = (rm == RND_FLOOR) ? fl(y_r) :
                         (rm == RND_CEIL) ? -fl(-y_r) :
                         (rm == RND_NEAREST) ? fl(y_r + `ASC_HALF) : y_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r <= S_IDLE;
      ch_r <= '0;
      x_r  <= '0;
      y_r  <= '0;
      k_r  <= '0;
      lo_r <= '0;
      hi_r <= '0;
      prev_r <= '0;
    end else begin
      case (st_r)
        S_IDLE: if (f_valid) begin
          ch_r   <= f_out.ch;
          x_r    <= f_out.val;
          k_r    <= 5'h1;
          lo_r   <= 5'h0;
          prev_r <= 5'h0;
          st_r   <= S_SRCH;
        end
        S_SRCH: begin
          // first used point at or above the input
          if (k_used && (x_r <= kp.in || k_last)) begin
            hi_r <= k_r;
            st_r <= S_CALC;
          end else if (k_used) begin
            prev_r <= lo_r;
            lo_r   <= k_r;
          end else if (k_last) begin
            hi_r <= lo_r;
            lo_r <= prev_r;
            st_r <= S_CALC;
          end
          if (!k_last) k_r <= k_r + 5'h1;
        end
        S_CALC: begin
          y_r  <= y_int;
          st_r <= S_RND;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) for (int i = 0; i < NCH; i++) curve_output_value[i] <= '0;
    else if (st_r == S_RND) curve_output_value[ch_r] <= y_rnd;
  end

  property p_tick;
    tick_r |=> !tick_r [*1];
  endproperty
  a_tick: assert property (p_tick) else $error("tick longer than one cycle");
  property p_hold;
    push && !x_ok |=> curve_input_value[$past(pick_idx)] == $past(curve_input_value[pick_idx]);
  endproperty
  a_hold: assert property (p_hold) else $error("value not held on loss");
  property p_raw;
    push && x_ok && !pc.filt_en |=> curve_input_value[$past(pick_idx)] == $past(x_raw);
  endproperty
  a_raw: assert property (p_raw) else $error("raw value altered");
  property p_filt;
    push && x_ok && pc.filt_en && x_raw >= y_old |-> push_val >= y_old && push_val <= x_raw;
  endproperty
  a_filt: assert property (p_filt) else $error("average outside step");
  property p_lo;
    push && pc.range_en && push_val < pc.lim_lo && pc.en
      |=> curve_input_range_alarm[$past(pick_idx)];
  endproperty
  a_lo: assert property (p_lo) else $error("low limit missed");
  property p_hi;
    push && pc.range_en && push_val > pc.lim_hi && pc.en
      |=> curve_input_range_alarm[$past(pick_idx)];
  endproperty
  a_hi: assert property (p_hi) else $error("high limit missed");
  property p_in;
    push && pc.en && push_val >= pc.lim_lo && push_val <= pc.lim_hi
      |=> !curve_input_range_alarm[$past(pick_idx)];
  endproperty
  a_in: assert property (p_in) else $error("alarm inside limits");
  sequence s_pop;
    st_r == S_IDLE && f_valid ##1 st_r == S_SRCH;
  endsequence
  property p_srch;
    s_pop |-> ##[1:20] st_r == S_CALC ##1 st_r == S_RND ##1 st_r == S_IDLE;
  endproperty
  a_srch: assert property (p_srch) else $error("curve walk too long");
  property p_rnd;
    st_r == S_RND && rm != RND_FLOAT
      |=> curve_output_value[$past(ch_r)] % `ASC_SCALE == 0;
  endproperty
  a_rnd: assert property (p_rnd) else $error("integer output not whole");
endmodule // asc_curve
`default_nettype wire

// *** pkg/asc_curve_regs.svh ***
// constants of the analog input scaling curve block
// assumes a 100 MHz system clock and fixed-point values in 0.00001 units
`ifndef ASC_CURVE_REGS_SVH
`define ASC_CURVE_REGS_SVH
`define ASC_DW         40
`define ASC_NCH        10
`define ASC_NPT        20
`define ASC_NSRC       32
`define ASC_FIFO_DEPTH 16
`define ASC_CLK_HZ     100000000
`define ASC_STEP_MS    5
`define ASC_TICK_CYC   (`ASC_CLK_HZ / 1000 * `ASC_STEP_MS)
`define ASC_SCALE      40'sh00000186A0
`define ASC_HALF       40'sh000000C350
`define ASC_TAU_DEF    20'hC8
`define ASC_UPD_DEF    11'h1E
`define ASC_PT1_IN_DEF 40'sh0000000000
`define ASC_PT2_IN_DEF `ASC_SCALE
`endif

// *** pkg/asc_pkg.sv ***
// types of the analog input scaling curve block
// assumes asc_curve_regs.svh is on the include path
`include "asc_curve_regs.svh"
package asc_pkg;
  typedef logic signed [`ASC_DW-1:0] asc_val_t;
  typedef enum logic [1:0] {RND_FLOAT, RND_FLOOR, RND_CEIL, RND_NEAREST} asc_rnd_t;
  typedef enum logic [1:0] {S_IDLE, S_SRCH, S_CALC, S_RND} asc_st_t;
  typedef struct packed {
    logic      en;
    logic      filt_en;
    logic      range_en;
    asc_rnd_t  rnd;
    logic [4:0]  src;
    logic [10:0] upd;
    logic [19:0] tau;
    asc_val_t  lim_lo;
    asc_val_t  lim_hi;
  } asc_cfg_t;
  typedef struct packed {
    logic     used;
    asc_val_t in;
    asc_val_t out;
  } asc_pt_t;
  typedef struct packed {
    logic [3:0] ch;
    asc_val_t   val;
  } asc_smp_t;
endpackage

// *** test/asc_src_model.sv ***
// measurement source model for the scaling curve block
// assumes bench requests arrive on clk_sys; only source 0 is live
`timescale 1ns/1ps
`default_nettype none
module asc_src_model import asc_pkg::*; (
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rstn,
  // bench request
  input  wire logic            wr,
  input  wire asc_val_t        val,
  input  wire logic            ok,
  // source outputs
  output asc_val_t             meas_val [`ASC_NSRC],
  output logic [`ASC_NSRC-1:0] meas_valid
);
  asc_val_t last_r;
  logic     ok_r;
  // latch the value of the last request
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      last_r <= '0;
      ok_r   <= 1'b0;
    end else if (wr) begin
      last_r <= val;
      ok_r   <= ok;
    end
  end
  // a lost line shows junk, never the held value, so the block must keep its own copy
  always_comb begin
    foreach (meas_val[i]) meas_val[i] = ~last_r;
    meas_valid = '0;
    if (ok_r) meas_val[0] = last_r;
    meas_valid[0] = ok_r;
  end
endmodule // asc_src_model
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench of the scaling curve block, channel 0 exercised
// assumes a short tick of 20 cycles so that one sample lands every 20 cycles
`timescale 1ns/1ps
`default_nettype none
`include "asc_curve_regs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %0d got %0d", n, e, g); end end
module testbench import asc_pkg::*;;
  logic           clk_sys = 1'b0;
  logic           rstn    = 1'b0;
  logic           wr      = 1'b0;
  logic           sok     = 1'b0;
  asc_val_t       sval    = '0;
  asc_val_t       meas_val [`ASC_NSRC];
  logic [31:0]    meas_valid;
  asc_cfg_t       cfg [10];
  asc_pt_t        pt [10][20];
  asc_val_t       curve_input_value [10];
  asc_val_t       curve_output_value [10];
  logic [9:0]     curve_input_range_alarm;
  int             n_mismatch = 0;
  int             cmp_count  = 0;
  // free-running 100 MHz clock
  always #5 clk_sys = ~clk_sys;
  asc_src_model i_src (.clk_sys(clk_sys), .rstn(rstn), .wr(wr), .val(sval), .ok(sok),
    .meas_val(meas_val), .meas_valid(meas_valid));
  asc_curve #(.TICK_CYC(20)) i_dut (.clk_sys(clk_sys), .rstn(rstn), .meas_val(meas_val),
    .meas_valid(meas_valid), .cfg(cfg), .pt(pt), .curve_input_value(curve_input_value),
    .curve_output_value(curve_output_value), .curve_input_range_alarm(curve_input_range_alarm));
  // one request to source 0
  task put(input asc_val_t v, input logic k);
    @(posedge clk_sys);
    wr   <= 1'b1;
    sval <= v;
    sok  <= k;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  // long enough for one tick plus the longest search
  task settle;
    repeat (70) @(posedge clk_sys);
    #1;
  endtask
  task wait_chg(input asc_val_t old);
    int n;
    n = 0;
    #1;
    while (curve_input_value[0] === old && n < 200) begin
      @(posedge clk_sys); #1; n++;
    end
    if (n >= 200) begin n_mismatch++; $display("BAD wait_chg exp change got none"); end
  endtask
  task summarize;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task t_reset;
    #1;
    `CHK("alarm", 10'h000, curve_input_range_alarm)
    `CHK("in0", 40'sh0, curve_input_value[0])
  endtask
  task t_line;
    @(posedge clk_sys);
    cfg[0].en    <= 1'b1;
    pt[0][1].out <= 40'sh30D40;
    put(`ASC_HALF, 1'b1);
    wait_chg(40'sh0);
    repeat (30) @(posedge clk_sys);
    #1;
    `CHK("in0", `ASC_HALF, curve_input_value[0])
    `CHK("out0", `ASC_SCALE, curve_output_value[0])
    `CHK("out1", 40'sh0, curve_output_value[1])
  endtask
  task t_round;
    asc_val_t ex [4];
    ex = '{40'sh1E848, 40'sh186A0, 40'sh30D40, 40'sh186A0};
    @(posedge clk_sys);
    pt[0][1].out <= `ASC_SCALE;
    put(40'sh1E848, 1'b1);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys);
      cfg[0].rnd <= asc_rnd_t'(m);
      settle;
      `CHK("round", ex[m], curve_output_value[0])
    end
  endtask
  task t_multi;
    @(posedge clk_sys);
    cfg[0].rnd <= RND_FLOAT;
    pt[0][2] <= '{1'b0, 40'sh1D4C0, 40'sh7FFFF};
    pt[0][3] <= '{1'b1, 40'sh30D40, 40'sh7A120};
    put(40'sh249F0, 1'b1);
    settle;
    `CHK("multi", 40'sh493E0, curve_output_value[0])
    @(posedge clk_sys);
    pt[0][3].used <= 1'b0;
  endtask
  task t_range;
    asc_val_t v [5];
    logic     e [5];
    v = '{40'sh0C350, 40'sh30D40, 40'sh61A80, 40'sh493E0, 40'sh61A80};
    e = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    @(posedge clk_sys);
    cfg[0].range_en <= 1'b1;
    cfg[0].lim_lo   <= `ASC_SCALE;
    cfg[0].lim_hi   <= 40'sh493E0;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      if (i == 4) cfg[0].range_en <= 1'b0;
      put(v[i], 1'b1);
      settle;
      `CHK("alarm0", e[i], curve_input_range_alarm[0])
    end
  endtask
  // hold on lost signal, dead source chosen
  task t_hold;
    put(40'sh30D40, 1'b1);
    settle;
    @(posedge clk_sys);
    cfg[0].src <= 5'h01;
    put(40'sh61A80, 1'b1);
    settle;
    `CHK("src1", 40'sh30D40, curve_input_value[0])
    put(40'sh61A80, 1'b0);
    @(posedge clk_sys);
    cfg[0].src <= 5'h00;
    settle;
    `CHK("hold_in", 40'sh30D40, curve_input_value[0])
    `CHK("hold_out", 40'sh30D40, curve_output_value[0])
  endtask
  task t_upd;
    @(posedge clk_sys);
    cfg[0].upd <= 11'h003;
    put(`ASC_HALF, 1'b1);
    wait_chg(40'sh30D40);
    put(40'sh249F0, 1'b1);
    repeat (40) @(posedge clk_sys);
    #1;
    `CHK("upd_old", `ASC_HALF, curve_input_value[0])
    wait_chg(`ASC_HALF);
    `CHK("upd_new", 40'sh249F0, curve_input_value[0])
    @(posedge clk_sys);
    cfg[0].upd <= 11'h001;
  endtask
  // first order steps; tau four times the update period
  task t_filter;
    put(40'sh0, 1'b1);
    settle;
    @(posedge clk_sys);
    cfg[0].filt_en <= 1'b1;
    cfg[0].tau     <= 20'h00004;
    put(40'sh61A80, 1'b1);
    wait_chg(40'sh0);
    `CHK("filt1", 40'sh186A0, curve_input_value[0])
    wait_chg(40'sh186A0);
    `CHK("filt2", 40'sh2AB98, curve_input_value[0])
    put(40'sh0, 1'b1);
    wait_chg(40'sh2AB98);
    `CHK("filt3", 40'sh200B2, curve_input_value[0])
  endtask
  initial begin
    for (int c = 0; c < 10; c++) begin
      cfg[c]     = '0;
      cfg[c].upd = 11'h001;
      cfg[c].tau = 20'h00001;
      for (int p = 0; p < 20; p++) pt[c][p] = '0;
      pt[c][0].used = 1'b1;
      pt[c][1].used = 1'b1;
      pt[c][1].in   = `ASC_SCALE;
      pt[c][1].out  = `ASC_SCALE;
    end
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset;
    t_line;
    t_round;
    t_multi;
    t_range;
    t_hold;
    t_upd;
    t_filter;
    summarize;
  end
  // watchdog well beyond the roughly 1300 cycles of the sequence
  initial begin
    #300000;
    n_mismatch++;
    summarize;
  end
endmodule // testbench
`default_nettype wire
